/* File: design/cfmi_pkg.sv */
// Constants, types and register map of the CAN filter, mask and interrupt flag block.
// Assumes an 8-bit register port and event strobes from logic on the same clock.
package cfmi_pkg;

  // ----------------------------------------------------------------
  // Register port widths
  // ----------------------------------------------------------------
  localparam int CFMI_AW = 8;                        // Address width
  localparam int CFMI_DW = 8;                        // Data width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFMI_OFS_FLAGS     = 8'h00; // Interrupt flags
  localparam logic [7:0] CFMI_OFS_IRQ_MASK  = 8'h01; // Interrupt enable mask
  localparam logic [7:0] CFMI_OFS_MODE      = 8'h02; // Operating mode
  localparam logic [7:0] CFMI_OFS_MASK_BASE = 8'h04; // Two mask high bytes
  localparam logic [7:0] CFMI_OFS_FILT_HIGH = 8'h10; // Filter high bytes, 16 words
  localparam logic [7:0] CFMI_OFS_FILT_LOW  = 8'h20; // Filter low bytes, 16 words
  localparam logic [7:0] CFMI_FILT_SPAN     = 8'h10; // Words per filter page

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int         CFMI_NUM_FILTERS   = 16;    // Filters in modes 1 and 2
  localparam logic [3:0] CFMI_MODE0_FILTERS = 4'h6;  // Filters usable in mode 0
  localparam int         CFMI_NUM_MASKS     = 2;     // Acceptance masks

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int CFMI_BIT_BUS_ERR = 7;               // Invalid message seen
  localparam int CFMI_BIT_WAKE    = 6;               // Bus activity
  localparam int CFMI_BIT_MOD_ERR = 5;               // Module error
  localparam int CFMI_BIT_TX_HI   = 4;               // Tx buffer 2 / any tx
  localparam int CFMI_BIT_TX1     = 3;               // Tx buffer 1
  localparam int CFMI_BIT_TX0     = 2;               // Tx buffer 0
  localparam int CFMI_BIT_RX_HI   = 1;               // Rx buffer 1 / any rx
  localparam int CFMI_BIT_RX_LO   = 0;               // Rx buffer 0 / watermark

  // ----------------------------------------------------------------
  // Reset values and per-mode implemented flag bits
  // ----------------------------------------------------------------
  localparam logic [7:0] CFMI_FLAGS_RST    = 8'h00;  // Flags clear at reset
  localparam logic [7:0] CFMI_IRQ_MASK_RST = 8'h00;  // All sources masked
  localparam logic [7:0] CFMI_KEEP_MODE0   = 8'hFF;  // Every flag live
  localparam logic [7:0] CFMI_KEEP_MODE1   = 8'hF2;  // Bits 3, 2, 0 forced low
  localparam logic [7:0] CFMI_KEEP_MODE2   = 8'hF3;  // Bits 3, 2 forced low

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFMI_MODE_LEGACY   = 2'h0,                       // Mode 0
    CFMI_MODE_ENHANCED = 2'h1,                       // Mode 1
    CFMI_MODE_FIFO     = 2'h2                        // Mode 2
  } cfmi_mode_t;

  localparam cfmi_mode_t CFMI_MODE_RST = CFMI_MODE_LEGACY;

  // Event strobes from the CAN engine, one cycle each
  typedef struct packed {
    logic       invalid_msg;                         // Invalid message on bus
    logic       bus_activity;                        // Any bus activity
    logic [2:0] tx_done;                             // Tx buffer finished, per buffer
    logic [1:0] rx_full;                             // Rx buffer loaded, per buffer
    logic       fifo_watermark;                      // Rx FIFO high watermark
  } cfmi_events_t;

  // Whole register state of the block
  typedef struct packed {
    logic [7:0]                              flags;     // Interrupt flags
    logic [7:0]                              irq_mask;  // Interrupt mask
    cfmi_mode_t                              mode;      // Operating mode
    logic [CFMI_NUM_MASKS-1:0][7:0]          mask_high; // Mask high bytes
    logic [CFMI_NUM_FILTERS-1:0][7:0]        filt_high; // Filter id bits 15..8
    logic [CFMI_NUM_FILTERS-1:0][7:0]        filt_low;  // Filter id bits 7..0
    logic [7:0]                              rdata;     // Read data holding stage
  } cfmi_state_t;

endpackage

/* File: design/cfmi_regs.sv */
// CAN acceptance filter bytes, mask high bytes and mode-dependent interrupt flags.
// Assumes event strobes and the register port come from logic on CLOCK.
//
// Functional notes
// RULE1: Invalid bus message sets flag bit 7.
// RULE2: Bus activity sets wake flag bit 6.
// RULE3: Any internal error source sets bit 5.
// RULE4: Mode 0: bit 4 flags tx buffer 2.
// RULE5: Modes 1, 2: bit 4 flags any tx.
// RULE6: Bits 3, 2 tx 1, 0; zero otherwise.
// RULE7: Mode 0: bit 1 flags rx buffer 1.
// RULE8: Modes 1, 2: bit 1 flags any rx.
// RULE9: Mode 0: bit 0 flags rx buffer 0.
// RULE10: Mode 2 watermark on bit 0; mode 1 zero.
// RULE11: Filter byte holds id bits 15..8, unreset.
// RULE12: Filter byte holds id bits 7..0, unreset.
// RULE13: Filters 6..15 exist only in modes 1, 2.
// RULE14: Two mask high bytes, id 10..3 / 28..21.
// RULE15: Flags read zero after reset, read/write.
// RULE16: Set flag holds until software writes zero.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module cfmi_regs
  import cfmi_pkg::*;
#(
  parameter int NUM_ERR_SRC = 4                              // Internal error sources
) (
  input  wire logic                                CLOCK,      // System clock
  input  wire logic                                SYS_RST,    // Sync reset, high
  input  wire logic                                CLK_EN,     // Clock enable
  input  wire logic [CFMI_AW-1:0]                  ADDR,       // Register address
  input  wire logic [CFMI_DW-1:0]                  WDATA,      // Write data
  input  wire logic                                WR_STB,     // Write strobe
  input  wire logic                                RD_STB,     // Read strobe
  output logic      [CFMI_DW-1:0]                  RDATA,      // Read data, next cycle
  input  wire cfmi_events_t                        EVENTS,     // Engine event strobes
  input  wire logic [NUM_ERR_SRC-1:0]              ERR_SRC,    // Error source strobes
  output logic                                     IRQ,        // Interrupt level
  output cfmi_mode_t                               MODE,       // Current mode
  output logic [CFMI_NUM_FILTERS-1:0][15:0]        FILTER_EID, // Filter id bits 15..0
  output logic [CFMI_NUM_MASKS-1:0][7:0]           MASK_HIGH   // Mask high bytes
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // At least one error source must feed the module error flag
  if (NUM_ERR_SRC < 1) begin : g_bad_err
    $error("NUM_ERR_SRC must be at least one");
  end

  // ----------------------------------------------------------------
  // State and decode signals
  // ----------------------------------------------------------------
  cfmi_state_t st_reg;                                       // Registered state
  cfmi_state_t st_next;                                      // Next state
  logic        in_filt_hi;                                   // Address in high page
  logic        in_filt_lo;                                   // Address in low page
  logic        in_mask;                                      // Address hits a mask
  logic [3:0]  acc_idx;                                      // Filter index of access
  logic        filt_ok;                                      // Filter exists in mode
  logic [7:0]  page_off;                                     // Offset within page
  logic [7:0]  flag_set;                                     // Events this cycle
  logic [7:0]  flag_keep;                                    // Implemented flag bits

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Maps event strobes onto flag bits for a given mode
  function automatic logic [7:0] event_bits(input cfmi_mode_t m,
                                            input cfmi_events_t ev,
                                            input logic err_any);
    logic [7:0] v;
    v = 8'h00;
    // Bits 7 to 5 mean the same in every mode
    v[CFMI_BIT_BUS_ERR] = ev.invalid_msg;                    // RULE1
    v[CFMI_BIT_WAKE]    = ev.bus_activity;                   // RULE2
    v[CFMI_BIT_MOD_ERR] = err_any;                           // RULE3
    if (m == CFMI_MODE_LEGACY) begin
      // Per-buffer flags
      v[CFMI_BIT_TX_HI] = ev.tx_done[2];                     // RULE4
      v[CFMI_BIT_TX1]   = ev.tx_done[1];                     // RULE6
      v[CFMI_BIT_TX0]   = ev.tx_done[0];                     // RULE6
      v[CFMI_BIT_RX_HI] = ev.rx_full[1];                     // RULE7
      v[CFMI_BIT_RX_LO] = ev.rx_full[0];                     // RULE9
    end else begin
      // Summary flags, and the watermark on bit 0 in mode 2
      v[CFMI_BIT_TX_HI] = |ev.tx_done;                       // RULE5
      v[CFMI_BIT_RX_HI] = |ev.rx_full;                       // RULE8
      v[CFMI_BIT_RX_LO] = (m == CFMI_MODE_FIFO) && ev.fifo_watermark; // RULE10
    end
    return v;
  endfunction

  // Bits that exist in a given mode; others read as zero
  function automatic logic [7:0] keep_bits(input cfmi_mode_t m);
    logic [7:0] k;
    // Mode 0 keeps every flag bit
    k = CFMI_KEEP_MODE0;
    if (m == CFMI_MODE_ENHANCED) begin
      k = CFMI_KEEP_MODE1;                                   // RULE10
    end else if (m == CFMI_MODE_FIFO) begin
      k = CFMI_KEEP_MODE2;                                   // RULE6
    end
    return k;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Finds which page an access hits and whether the filter exists
  always_comb begin
    // Each filter page spans sixteen words
    in_filt_hi = (ADDR >= CFMI_OFS_FILT_HIGH) && (ADDR < CFMI_OFS_FILT_HIGH + CFMI_FILT_SPAN);
    in_filt_lo = (ADDR >= CFMI_OFS_FILT_LOW) && (ADDR < CFMI_OFS_FILT_LOW + CFMI_FILT_SPAN);
    in_mask    = (ADDR[7:1] == CFMI_OFS_MASK_BASE[7:1]);
    // Offset into whichever filter page is hit
    if (in_filt_hi) begin
      page_off = ADDR - CFMI_OFS_FILT_HIGH;
    end else begin
      page_off = ADDR - CFMI_OFS_FILT_LOW;
    end
    acc_idx = page_off[3:0];
    // Upper filters vanish in mode 0
    filt_ok = (st_reg.mode != CFMI_MODE_LEGACY) || (acc_idx < CFMI_MODE0_FILTERS); // RULE13
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Register writes, read capture and flag update in one pass
  always_comb begin
    st_next   = st_reg;
    flag_set  = 8'h00;
    flag_keep = CFMI_KEEP_MODE0;
    if (CLK_EN) begin
      st_next.rdata = 8'h00;                                 // Read data lasts one cycle
      // Writes
      if (WR_STB) begin
        if (ADDR == CFMI_OFS_FLAGS) begin
          // Zeros clear flags, ones leave them alone
          st_next.flags = st_reg.flags & WDATA;              // RULE16
        end else if (ADDR == CFMI_OFS_IRQ_MASK) begin
          st_next.irq_mask = WDATA;
        end else if (ADDR == CFMI_OFS_MODE) begin
          // Undefined mode codes are ignored
          if (WDATA[1:0] <= 2'(CFMI_MODE_FIFO)) begin
            st_next.mode = cfmi_mode_t'(WDATA[1:0]);
          end
        end else if (in_mask) begin
          // Address bit 0 picks the mask
          st_next.mask_high[ADDR[0]] = WDATA;                // RULE14
        end else if (in_filt_hi && filt_ok) begin
          // Absent filters in mode 0 swallow the write
          st_next.filt_high[acc_idx] = WDATA;                // RULE11
        end else if (in_filt_lo && filt_ok) begin
          // Same guard as the high page
          st_next.filt_low[acc_idx] = WDATA;                 // RULE12
        end
      end
      // Reads, unmapped and absent filters give zero
      if (RD_STB) begin
        if (ADDR == CFMI_OFS_FLAGS) begin
          // Flags read back as held
          st_next.rdata = st_reg.flags;                      // RULE15
        end else if (ADDR == CFMI_OFS_IRQ_MASK) begin
          st_next.rdata = st_reg.irq_mask;
        end else if (ADDR == CFMI_OFS_MODE) begin
          // Mode sits in the two low bits
          st_next.rdata = {6'h00, st_reg.mode};
        end else if (in_mask) begin
          st_next.rdata = st_reg.mask_high[ADDR[0]];         // RULE14
        end else if (in_filt_hi && filt_ok) begin
          st_next.rdata = st_reg.filt_high[acc_idx];         // RULE11
        end else if (in_filt_lo && filt_ok) begin
          st_next.rdata = st_reg.filt_low[acc_idx];          // RULE12
        end
      end
      // Events set flags after the write, so a set beats a clear
      flag_set      = event_bits(st_next.mode, EVENTS, |ERR_SRC);
      // Bits the new mode lacks drop at once
      flag_keep     = keep_bits(st_next.mode);
      st_next.flags = (st_next.flags | flag_set) & flag_keep; // RULE16
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Filters and masks keep no reset value
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_reg.flags    <= CFMI_FLAGS_RST;                     // RULE15
      st_reg.irq_mask <= CFMI_IRQ_MASK_RST;
      st_reg.mode     <= CFMI_MODE_RST;
      st_reg.rdata    <= 8'h00;
    end else begin
      // Clock enable is already folded into st_next
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Filter bytes joined into 16-bit identifier fields
  for (genvar i = 0; i < CFMI_NUM_FILTERS; i++) begin : g_filt
    assign FILTER_EID[i] = {st_reg.filt_high[i], st_reg.filt_low[i]};
  end

  // Read data and mode come straight from flip-flops
  assign RDATA     = st_reg.rdata;
  assign MODE      = st_reg.mode;
  assign MASK_HIGH = st_reg.mask_high;
  // Level interrupt while any unmasked flag is set
  assign IRQ       = |(st_reg.flags & st_reg.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // Write of a legal filter high byte
  sequence s_wr_filt_hi;
    CLK_EN && WR_STB && in_filt_hi && filt_ok;
  endsequence

  // Write of a legal filter low byte
  sequence s_wr_filt_lo;
    CLK_EN && WR_STB && in_filt_lo && filt_ok;
  endsequence

  // Read of an upper filter while in mode 0
  sequence s_rd_absent_filt;
    CLK_EN && RD_STB && (in_filt_hi || in_filt_lo) && !filt_ok;
  endsequence

  // Write to a mask byte followed by a read of either mask byte
  sequence s_mask_round_trip;
    CLK_EN && WR_STB && in_mask ##1 CLK_EN && RD_STB && in_mask;
  endsequence

  chk_invalid_msg_flag: assert property ( // RULE1
    CLK_EN && EVENTS.invalid_msg |=> st_reg.flags[CFMI_BIT_BUS_ERR])
    else $error("invalid message did not set its flag");

  chk_wake_flag_set: assert property ( // RULE2
    CLK_EN && EVENTS.bus_activity
    |=> st_reg.flags[CFMI_BIT_WAKE] && (IRQ || !st_reg.irq_mask[CFMI_BIT_WAKE]))
    else $error("bus activity did not set wake flag");

  chk_module_error_or: assert property ( // RULE3
    CLK_EN && (|ERR_SRC) |=> st_reg.flags[CFMI_BIT_MOD_ERR])
    else $error("error source did not set module error flag");

  chk_tx2_mode0: assert property ( // RULE4
    CLK_EN && EVENTS.tx_done[2] && st_next.mode == CFMI_MODE_LEGACY
    |=> st_reg.flags[CFMI_BIT_TX_HI])
    else $error("tx buffer 2 done not flagged in mode 0");

  chk_any_tx_summary: assert property ( // RULE5
    CLK_EN && (|EVENTS.tx_done) && st_next.mode != CFMI_MODE_LEGACY
    |=> st_reg.flags[CFMI_BIT_TX_HI])
    else $error("tx done not flagged on summary bit");

  chk_tx_low_forced: assert property ( // RULE6
    st_reg.mode != CFMI_MODE_LEGACY |-> st_reg.flags[CFMI_BIT_TX1:CFMI_BIT_TX0] == 2'h0)
    else $error("tx buffer flags not zero outside mode 0");

  chk_rx_mode0_flags: assert property ( // RULE7
    CLK_EN && st_next.mode == CFMI_MODE_LEGACY && EVENTS.rx_full[1]
    |=> st_reg.flags[CFMI_BIT_RX_HI])
    else $error("rx buffer 1 not flagged in mode 0");

  chk_any_rx_summary: assert property ( // RULE8
    CLK_EN && st_next.mode != CFMI_MODE_LEGACY && (|EVENTS.rx_full)
    |=> st_reg.flags[CFMI_BIT_RX_HI])
    else $error("rx full not flagged on summary bit");

  chk_rx0_mode0_flag: assert property ( // RULE9
    CLK_EN && st_next.mode == CFMI_MODE_LEGACY && EVENTS.rx_full[0]
    |=> st_reg.flags[CFMI_BIT_RX_LO])
    else $error("rx buffer 0 not flagged in mode 0");

  chk_bit0_mode1_zero: assert property ( // RULE10
    st_reg.mode == CFMI_MODE_ENHANCED |-> !st_reg.flags[CFMI_BIT_RX_LO])
    else $error("bit 0 set in mode 1");

  chk_filter_high_store: assert property ( // RULE11
    s_wr_filt_hi |=> FILTER_EID[$past(acc_idx)][15:8] == $past(WDATA))
    else $error("filter high byte not stored");

  chk_filter_low_store: assert property ( // RULE12
    s_wr_filt_lo |=> FILTER_EID[$past(acc_idx)][7:0] == $past(WDATA))
    else $error("filter low byte not stored");

  chk_absent_filter_read: assert property ( // RULE13
    s_rd_absent_filt |=> RDATA == 8'h00)
    else $error("absent filter did not read zero");

  chk_mask_read_back: assert property ( // RULE14
    s_mask_round_trip ##0 (ADDR == $past(ADDR)) |=> RDATA == $past(WDATA, 2))
    else $error("mask byte did not read back");

  chk_flags_after_reset: assert property (disable iff (1'b0) // RULE15
    SYS_RST |=> st_reg.flags == CFMI_FLAGS_RST)
    else $error("flags not clear after reset");

  chk_flag_hold_set: assert property ( // RULE16
    st_reg.flags[CFMI_BIT_BUS_ERR]
    && !(CLK_EN && WR_STB && ADDR == CFMI_OFS_FLAGS && !WDATA[CFMI_BIT_BUS_ERR])
    |=> st_reg.flags[CFMI_BIT_BUS_ERR])
    else $error("set flag dropped without a zero write");

  // Writing zero with no event pending clears every flag
  chk_flag_zero_clear: assert property ( // RULE16
    CLK_EN && WR_STB && ADDR == CFMI_OFS_FLAGS && WDATA == 8'h00
    && EVENTS == '0 && ERR_SRC == '0 |=> st_reg.flags == 8'h00)
    else $error("zero write did not clear flags");

  // A flag write never raises a flag by itself
  chk_flag_write_no_set: assert property ( // RULE16
    CLK_EN && WR_STB && ADDR == CFMI_OFS_FLAGS && EVENTS == '0 && ERR_SRC == '0
    |=> (st_reg.flags & ~$past(st_reg.flags)) == 8'h00)
    else $error("flag write set a flag");

  // Mask bytes take the written value
  chk_mask_store: assert property ( // RULE14
    CLK_EN && WR_STB && in_mask |=> MASK_HIGH[$past(ADDR[0])] == $past(WDATA))
    else $error("mask byte not stored");

  // Read data fall back to zero without a read
  chk_rdata_one_cycle: assert property (
    CLK_EN && !RD_STB |=> RDATA == 8'h00)
    else $error("read data not cleared after one cycle");

  // A write of the undefined mode code leaves the mode alone
  chk_mode_code_ignored: assert property (
    CLK_EN && WR_STB && ADDR == CFMI_OFS_MODE && WDATA[1:0] == 2'h3 |=> $stable(MODE))
    else $error("undefined mode code was taken");

  // Clock enable low freezes flags, read data and mode
  chk_frozen_hold: assert property (
    !CLK_EN |=> $stable(st_reg.flags) && $stable(RDATA) && $stable(MODE))
    else $error("state moved while clock enable was low");

endmodule

/* File: testbench/cfmi_engine_model.sv */
// Model of the CAN engine that feeds event and error strobes to the flag block.
// Assumes requests come from the bench on the same clock as the design.
`timescale 1ns/1ps

module cfmi_engine_model
  import cfmi_pkg::*;
#(
  parameter int NUM_ERR_SRC = 4                  // Error source count
) (
  input  wire logic                   clock,     // System clock
  input  wire logic                   fire,      // Emit the requested strobes
  input  wire cfmi_events_t           ev_req,    // Events to emit
  input  wire logic [NUM_ERR_SRC-1:0] err_req,   // Error sources to emit
  output cfmi_events_t                events,    // Event strobes to the block
  output logic [NUM_ERR_SRC-1:0]      err_src    // Error strobes to the block
);
  // ----------------------------------------------------------------
  // Strobe stage
  // ----------------------------------------------------------------
  // Each strobe follows fire one cycle later and drops one cycle after fire does, so a stuck strobe cannot mask a lost event
  always_ff @(posedge clock) begin
    events  <= fire ? ev_req : cfmi_events_t'(8'h00);
    err_src <= fire ? err_req : '0;
  end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the CAN filter, mask and interrupt flag block.
// Assumes the engine model drives the event strobes and the bench the register port.
`timescale 1ns/1ps

module tb
  import cfmi_pkg::*;
;
  localparam int NERR  = 4;                      // Error sources
  localparam int LIMIT = 5000;                   // Cycle ceiling of the run
  logic                              clock, sys_rst, clk_en, wr_stb, rd_stb, fire;
  logic [7:0]                        addr, wdata, rdata, got, expf;
  cfmi_events_t                      events, ev_req;
  logic [NERR-1:0]                   err_src, err_req;
  logic                              irq;
  cfmi_mode_t                        mode_o;
  logic [CFMI_NUM_FILTERS-1:0][15:0] filt_eid;
  logic [CFMI_NUM_MASKS-1:0][7:0]    mask_high;
  int                                n_errors, comparisons;
  int                                cycles = 0;

  cfmi_regs #(.NUM_ERR_SRC(NERR)) cfmi_regs_i (.CLOCK(clock), .SYS_RST(sys_rst),
    .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata), .EVENTS(events), .ERR_SRC(err_src), .IRQ(irq), .MODE(mode_o),
    .FILTER_EID(filt_eid), .MASK_HIGH(mask_high));
  cfmi_engine_model #(.NUM_ERR_SRC(NERR)) cfmi_engine_model_i (.clock(clock), .fire(fire),
    .ev_req(ev_req), .err_req(err_req), .events(events), .err_src(err_src));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // A hang counts as a mismatch and closes the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  // With now set, the read follows the previous strobe with no gap
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp,
                      input bit now = 1'b0);
    if (!now) @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 got = rdata;
    chk(what, exp, got);
  endtask
  // Ask the engine model for one burst of strobes, then let the flags settle
  task automatic ev(input logic [7:0] e, input logic [NERR-1:0] s);
    @(posedge clock);
    fire    <= 1'b1;
    ev_req  <= cfmi_events_t'(e);
    err_req <= s;
    @(posedge clock);
    fire    <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // Flag expected from event bit k (8 means an error source) in mode m
  function automatic logic [7:0] flag_of(input int m, input int k);
    case (k)
      7: return 8'h80;
      6: return 8'h40;
      5: return 8'h10;
      4: return (m == 0) ? 8'h08 : 8'h10;
      3: return (m == 0) ? 8'h04 : 8'h10;
      2: return 8'h02;
      1: return (m == 0) ? 8'h01 : 8'h02;
      0: return (m == 2) ? 8'h01 : 8'h00;
      default: return 8'h20;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {wr_stb, rd_stb, fire} = 3'b000;
    {addr, wdata} = 16'h0000;
    ev_req = cfmi_events_t'(8'h00);
    err_req = '0;
    n_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rchk("flags reset", CFMI_OFS_FLAGS, 8'h00);
    chk("irq reset", 8'h00, {7'h00, irq});
    rchk("mode reset", CFMI_OFS_MODE, 8'h00);
    wr(8'h10, 8'hA5);
    wr(8'h20, 8'h5A);
    wr(8'h15, 8'hC3);
    wr(8'h25, 8'h3C);
    wr(8'h16, 8'h77);
    rchk("filter0 high", 8'h10, 8'hA5);
    rchk("filter0 low", 8'h20, 8'h5A);
    chk("filter0 port", 8'hA5, filt_eid[0][15:8]);
    chk("filter0 port low", 8'h5A, filt_eid[0][7:0]);
    rchk("filter5 high", 8'h15, 8'hC3);
    rchk("filter5 low", 8'h25, 8'h3C);
    rchk("filter6 mode0", 8'h16, 8'h00);
    wr(8'h04, 8'hF0);
    wr(8'h05, 8'h0F);
    rchk("mask0", 8'h04, 8'hF0);
    rchk("mask1", 8'h05, 8'h0F);
    chk("mask1 port", 8'h0F, mask_high[1]);
    wr(8'h05, 8'h3C);
    rchk("mask1 back to back", 8'h05, 8'h3C, 1'b1);
    wr(8'h3F, 8'hFF);
    rchk("unmapped", 8'h3F, 8'h00);
    // Frozen clock enable: neither writes nor events land
    @(posedge clock) clk_en <= 1'b0;
    wr(8'h04, 8'h11);
    ev(8'h80, '0);
    @(posedge clock) clk_en <= 1'b1;
    rchk("mask0 frozen", 8'h04, 8'hF0);
    rchk("flags frozen", CFMI_OFS_FLAGS, 8'h00);
    // Every event source in every mode, with all interrupts enabled
    wr(CFMI_OFS_IRQ_MASK, 8'hFF);
    for (int m = 0; m < 3; m++) begin
      wr(CFMI_OFS_MODE, 8'(m));
      rchk("mode", CFMI_OFS_MODE, 8'(m));
      chk("mode port", 8'(m), {6'h00, mode_o});
      if (m == 1) begin
        wr(8'h1F, 8'h9E);
        rchk("filter15 mode1", 8'h1F, 8'h9E);
      end
      for (int k = 0; k < 9; k++) begin
        expf = flag_of(m, k);
        ev((k < 8) ? (8'h01 << k) : 8'h00, (k == 8) ? NERR'(1 << m) : '0);
        rchk("flag", CFMI_OFS_FLAGS, expf);
        chk("irq level", {7'h00, expf != 8'h00}, {7'h00, irq});
        wr(CFMI_OFS_FLAGS, 8'h00);
        rchk("flag cleared", CFMI_OFS_FLAGS, 8'h00);
      end
    end
    // Sticky flags: only written zeros clear, ones never set
    wr(CFMI_OFS_MODE, 8'h00);
    ev(8'hC0, '0);
    wr(CFMI_OFS_FLAGS, 8'hBF);
    rchk("partial clear", CFMI_OFS_FLAGS, 8'h80);
    wr(CFMI_OFS_FLAGS, 8'hFF);
    rchk("write ones", CFMI_OFS_FLAGS, 8'h80);
    wr(CFMI_OFS_IRQ_MASK, 8'h7F);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    wr(CFMI_OFS_IRQ_MASK, 8'h80);
    #1 chk("irq unmasked", 8'h01, {7'h00, irq});
    wr(CFMI_OFS_FLAGS, 8'h00);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    // Mode 0 only bits vanish on a switch to mode 1
    ev(8'h12, '0);
    rchk("mode0 tx1 rx0", CFMI_OFS_FLAGS, 8'h09);
    wr(CFMI_OFS_MODE, 8'h01);
    rchk("forced bits", CFMI_OFS_FLAGS, 8'h00);
    wr(CFMI_OFS_MODE, 8'h03);
    rchk("mode 3 ignored", CFMI_OFS_MODE, 8'h01);
    // Reset in mid-run
    ev(8'h80, '0);
    @(posedge clock) sys_rst <= 1'b1;
    @(posedge clock) sys_rst <= 1'b0;
    rchk("flags rerst", CFMI_OFS_FLAGS, 8'h00);
    rchk("mode rerst", CFMI_OFS_MODE, 8'h00);
    end_sim();
  end
endmodule
